/* hw/iorb_pkg.sv */
// Shared constants for the inertial output register bank
package iorb_pkg;
	// Register byte addresses, 7-bit space, 16-bit words
	localparam logic [6:0] ADDR_ACCEL_Z_FRACTION = 7'h18;
	localparam logic [6:0] ADDR_ACCEL_Z_WORD = 7'h1a;
	localparam logic [6:0] ADDR_DIE_TEMPERATURE = 7'h1c;
	localparam logic [6:0] ADDR_EDGE_ELAPSED_TIME = 7'h1e;
	localparam logic [6:0] ADDR_UPDATE_COUNTER = 7'h22;
	localparam logic [6:0] ADDR_ANGLE_X_LOW = 7'h24;
	localparam logic [6:0] ADDR_ANGLE_X_HIGH = 7'h26;
	// Width of the read address
	localparam int ADDR_W = 7;
	// Sync mode field of the miscellaneous control word
	localparam int MODE_LSB = 2;
	localparam int MODE_MSB = 4;
	localparam logic [2:0] MODE_SCALED_SYNC = 3'h2;
	// Reset values
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [31:0] ANGLE_RESET = 32'h0000_0000;
	// Time stamp resolution, in ns, and the clock period
	localparam int TS_LSB_NS = 49020;
	localparam int CLK_PERIOD_NS = 8;
	// Longest whole number of cycles inside one stamp count
	localparam int TS_TICK_CYCLES = TS_LSB_NS / CLK_PERIOD_NS;
	// Nominal internal sample rate the angle scale assumes
	localparam int SAMPLE_RATE_SPS = 2000;
	// Gyro rate sample width
	localparam int RATE_W = 24;
endpackage

/* hw/iorb_integrator.sv */
// Trapezoidal delta-angle integrator over one decimation period
`timescale 1ns/1ps
module iorb_integrator #(
	parameter int RATE_W = iorb_pkg::RATE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Reset command, clears the running sum
	input wire logic clear,
	// Pre-decimation rate samples
	input wire logic sample_valid,
	input wire logic signed [RATE_W-1:0] rate,
	input wire logic [15:0] decimation_setting,
	// Finished delta angle
	output logic [31:0] angle_r,
	output logic done_r
);
	// Previous rate sample, carried across periods
	logic signed [RATE_W-1:0] prev_r;
	// Running sum and samples taken so far
	logic [31:0] acc_r;
	logic [15:0] cnt_r;
	// Sum of this and the previous sample, sign extended
	logic [31:0] pair;
	logic [31:0] acc_nxt;
	// Last sample of the period
	logic last;

	// Pair sum and period end; rates arrive prescaled for the
	// Nominal internal sample rate, so no divider is spent here
	always_comb begin
		pair = 32'(rate) + 32'(prev_r);
		acc_nxt = acc_r + pair;
		last = (cnt_r == decimation_setting);
	end

	// Previous sample
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_r <= '0;
		end else if (clear) begin
			prev_r <= '0;
		end else if (sample_valid) begin
			prev_r <= rate;
		end
	end

	// Accumulate; sum restarts after the last sample of each period
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_r <= iorb_pkg::ANGLE_RESET;
			cnt_r <= iorb_pkg::COUNTER_RESET;
		end else if (clear) begin
			acc_r <= iorb_pkg::ANGLE_RESET;
			cnt_r <= iorb_pkg::COUNTER_RESET;
		end else if (sample_valid) begin
			// Decimation setting plus one samples per result
			if (last) begin
				acc_r <= iorb_pkg::ANGLE_RESET;
				cnt_r <= iorb_pkg::COUNTER_RESET;
			end else begin
				acc_r <= acc_nxt;
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	// Result and its one-cycle strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			angle_r <= iorb_pkg::ANGLE_RESET;
			done_r <= 1'b0;
		end else begin
			done_r <= sample_valid && last && !clear;
			if (sample_valid && last && !clear) begin
				angle_r <= acc_nxt;
			end
		end
	end

	// Result appears right after the sample that ends the period
	property p_period_end;
		@(posedge clk) disable iff (sys_rst)
		sample_valid && !clear && (cnt_r == decimation_setting) |=> done_r && angle_r == $past(acc_nxt);
	endproperty
	a_period_end: assert property (p_period_end) else $error("delta angle not produced at period end");

	// No result without a closing sample
	property p_no_early;
		@(posedge clk) disable iff (sys_rst)
		!(sample_valid && cnt_r == decimation_setting) |=> !done_r;
	endproperty
	a_no_early: assert property (p_no_early) else $error("delta angle strobe without period end");
endmodule

/* hw/iorb_top.sv */
// Output register bank: z accel, temperature, time stamp, counter, x delta angle
`timescale 1ns/1ps
module iorb_top #(
	parameter int RATE_W = iorb_pkg::RATE_W,
	// Clock cycles per time stamp count
	parameter int TS_TICK_CYCLES = iorb_pkg::TS_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Reset command from the control logic
	input wire logic reset_command,
	// Configuration words held elsewhere
	input wire logic [15:0] miscellaneous_control,
	input wire logic [15:0] decimation_setting,
	// Pre-decimation sensor samples
	input wire logic sample_valid,
	input wire logic signed [RATE_W-1:0] gyro_x_rate,
	input wire logic [31:0] accel_z_sample,
	input wire logic [15:0] temperature_sample,
	// External timing pin, asynchronous
	input wire logic sync_pin,
	// Register read port
	input wire logic rd_en,
	input wire logic [iorb_pkg::ADDR_W-1:0] rd_addr,
	output logic [15:0] rd_data_r,
	output logic rd_ack_r,
	// New data loaded
	output logic fresh_sample_pin_r
);
	// Output registers
	logic [31:0] accel_z_r;
	logic [15:0] die_temperature_r;
	logic [15:0] elapsed_time_r;
	logic [15:0] update_counter_r;
	logic [31:0] angle_x_r;
	// Latest sample, staged until the period closes
	logic [31:0] accel_stage_r;
	logic [15:0] temp_stage_r;
	// Sync pin synchroniser and filtered level
	logic sync_s1_r;
	logic sync_s2_r;
	logic sync_s3_r;
	logic sync_level_r;
	logic sync_edge;
	// Time stamp prescaler and running count
	logic [15:0] tick_cnt_r;
	logic [15:0] ts_count_r;
	logic [15:0] ts_stamp_r;
	// Integrator outputs, scaled mode decode and read word
	logic [31:0] angle_sum;
	logic update;
	logic scaled_mode;
	logic [15:0] rd_word;

	// Delta angle integrator
	iorb_integrator #(
		.RATE_W(RATE_W)
	) u_integ (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(reset_command),
		.sample_valid(sample_valid),
		.rate(gyro_x_rate),
		.decimation_setting(decimation_setting),
		.angle_r(angle_sum),
		.done_r(update)
	);

	// Scaled sync selected by bits 4:2
	assign scaled_mode = (miscellaneous_control[iorb_pkg::MODE_MSB:iorb_pkg::MODE_LSB]
		== iorb_pkg::MODE_SCALED_SYNC);

	// Pin synchroniser; first stage feeds only the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_s1_r <= 1'b0;
			sync_s2_r <= 1'b0;
			sync_s3_r <= 1'b0;
		end else begin
			sync_s1_r <= sync_pin;
			sync_s2_r <= sync_s1_r;
			sync_s3_r <= sync_s2_r;
		end
	end

	// Level accepted only when two stages agree, rejecting single glitches
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_level_r <= 1'b0;
		end else if (sync_s2_r == sync_s3_r) begin
			sync_level_r <= sync_s2_r;
		end
	end

	// Rising edge of the accepted level
	assign sync_edge = (sync_s2_r == sync_s3_r) && sync_s2_r && !sync_level_r;

	// Elapsed time since last edge, one count per stamp period
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt_r <= iorb_pkg::WORD_RESET;
			ts_count_r <= iorb_pkg::WORD_RESET;
		end else if (sync_edge) begin
			tick_cnt_r <= iorb_pkg::WORD_RESET;
			ts_count_r <= iorb_pkg::WORD_RESET;
		end else if (tick_cnt_r == 16'(TS_TICK_CYCLES - 1)) begin
			// Wraps after 16 bits; no edge for that long is out of range anyway
			tick_cnt_r <= iorb_pkg::WORD_RESET;
			ts_count_r <= ts_count_r + 16'h0001;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// Stamp of the newest sample, so the update carries its last sample's time
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ts_stamp_r <= iorb_pkg::WORD_RESET;
			accel_stage_r <= iorb_pkg::ANGLE_RESET;
			temp_stage_r <= iorb_pkg::WORD_RESET;
		end else if (sample_valid) begin
			ts_stamp_r <= ts_count_r;
			accel_stage_r <= accel_z_sample;
			temp_stage_r <= temperature_sample;
		end
	end

	// Output load: every word from the same update
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			accel_z_r <= iorb_pkg::ANGLE_RESET;
			die_temperature_r <= iorb_pkg::WORD_RESET;
			elapsed_time_r <= iorb_pkg::WORD_RESET;
			angle_x_r <= iorb_pkg::ANGLE_RESET;
		end else if (update) begin
			accel_z_r <= accel_stage_r;
			die_temperature_r <= temp_stage_r;
			angle_x_r <= angle_sum;
			// Zero outside scaled sync mode
			elapsed_time_r <= scaled_mode ? ts_stamp_r : iorb_pkg::WORD_RESET;
		end
	end

	// Update counter; reset command wins over an update
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			update_counter_r <= iorb_pkg::COUNTER_RESET;
		end else if (reset_command) begin
			update_counter_r <= iorb_pkg::COUNTER_RESET;
		end else if (update) begin
			update_counter_r <= update_counter_r + 16'h0001;
		end
	end

	// Data ready strobe follows each load
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fresh_sample_pin_r <= 1'b0;
		end else begin
			fresh_sample_pin_r <= update;
		end
	end

	// Read decode; either byte of a word selects it, unmapped reads zero
	always_comb begin
		case (rd_addr[iorb_pkg::ADDR_W-1:1])
			iorb_pkg::ADDR_ACCEL_Z_FRACTION[6:1]: rd_word = accel_z_r[15:0];
			iorb_pkg::ADDR_ACCEL_Z_WORD[6:1]: rd_word = accel_z_r[31:16];
			iorb_pkg::ADDR_DIE_TEMPERATURE[6:1]: rd_word = die_temperature_r;
			iorb_pkg::ADDR_EDGE_ELAPSED_TIME[6:1]: rd_word = elapsed_time_r;
			iorb_pkg::ADDR_UPDATE_COUNTER[6:1]: rd_word = update_counter_r;
			iorb_pkg::ADDR_ANGLE_X_LOW[6:1]: rd_word = angle_x_r[15:0];
			// Signed high word, LSB is full scale over 2^15
			// Full scale follows the range model through the rate prescale
			iorb_pkg::ADDR_ANGLE_X_HIGH[6:1]: rd_word = angle_x_r[31:16];
			default: rd_word = iorb_pkg::WORD_RESET;
		endcase
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_r <= iorb_pkg::WORD_RESET;
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= rd_en;
			if (rd_en) begin
				rd_data_r <= rd_word;
			end
		end
	end

	// Counter steps by exactly one on an update
	property p_cnt_inc;
		@(posedge clk) disable iff (sys_rst)
		update && !reset_command |=> update_counter_r == $past(update_counter_r) + 16'h0001;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("update counter did not step");

	// Counter holds between updates
	property p_cnt_hold;
		@(posedge clk) disable iff (sys_rst)
		!update && !reset_command |=> $stable(update_counter_r);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("update counter moved without update");

	// Reset command clears the counter
	property p_cnt_clear;
		@(posedge clk) disable iff (sys_rst)
		reset_command |=> update_counter_r == 16'h0000;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("update counter not cleared");

	// Both accel words come from the staged sample of this update
	property p_accel_pair;
		@(posedge clk) disable iff (sys_rst)
		update |=> accel_z_r == $past(accel_stage_r) && angle_x_r == $past(angle_sum);
	endproperty
	a_accel_pair: assert property (p_accel_pair) else $error("output pair torn across updates");

	// Stamp reads zero outside scaled sync mode
	property p_ts_off;
		@(posedge clk) disable iff (sys_rst)
		update && !scaled_mode |=> elapsed_time_r == 16'h0000;
	endproperty
	a_ts_off: assert property (p_ts_off) else $error("time stamp active outside scaled mode");

	// Edge restarts elapsed time
	property p_ts_edge;
		@(posedge clk) disable iff (sys_rst)
		sync_edge |=> ts_count_r == 16'h0000 && tick_cnt_r == 16'h0000;
	endproperty
	a_ts_edge: assert property (p_ts_edge) else $error("sync edge did not restart time");

	// High accel word read one cycle after request
	property p_rd_accel_hi;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr[6:1] == iorb_pkg::ADDR_ACCEL_Z_WORD[6:1] |=> rd_ack_r && rd_data_r == $past(accel_z_r[31:16]);
	endproperty
	a_rd_accel_hi: assert property (p_rd_accel_hi) else $error("accel high word read wrong");

	// Angle high word read returns the high half
	property p_rd_angle_hi;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr == 7'h26 |=> rd_ack_r && rd_data_r == $past(angle_x_r[31:16]);
	endproperty
	a_rd_angle_hi: assert property (p_rd_angle_hi) else $error("angle high word read wrong");

	// Temperature read returns the loaded word
	property p_rd_temp;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr == 7'h1c |=> rd_data_r == $past(die_temperature_r);
	endproperty
	a_rd_temp: assert property (p_rd_temp) else $error("temperature read wrong");

	// In scaled sync the update carries the last sample's stamp
	property p_ts_on;
		@(posedge clk) disable iff (sys_rst)
		update && scaled_mode |=> elapsed_time_r == $past(ts_stamp_r);
	endproperty
	a_ts_on: assert property (p_ts_on) else $error("time stamp not loaded with update");

	// Counter read returns the live count
	property p_rd_counter;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr[6:1] == iorb_pkg::ADDR_UPDATE_COUNTER[6:1] |=> rd_ack_r && rd_data_r == $past(update_counter_r);
	endproperty
	a_rd_counter: assert property (p_rd_counter) else $error("update counter read wrong");

	// Accel low word read returns the extra resolution bits
	property p_rd_accel_lo;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr[6:1] == iorb_pkg::ADDR_ACCEL_Z_FRACTION[6:1] |=> rd_ack_r && rd_data_r == $past(accel_z_r[15:0]);
	endproperty
	a_rd_accel_lo: assert property (p_rd_accel_lo) else $error("accel low word read wrong");

	// Angle low word read returns the low half
	property p_rd_angle_lo;
		@(posedge clk) disable iff (sys_rst)
		rd_en && rd_addr[6:1] == iorb_pkg::ADDR_ANGLE_X_LOW[6:1] |=> rd_ack_r && rd_data_r == $past(angle_x_r[15:0]);
	endproperty
	a_rd_angle_lo: assert property (p_rd_angle_lo) else $error("angle low word read wrong");
endmodule

/* dv/iorb_host.sv */
// Host model that reads the output registers and counts data-ready pulses
`timescale 1ns/1ps
module iorb_host (
	// Clock
	input wire logic clk,
	// Read port, host side
	output logic rd_en,
	output logic [iorb_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [15:0] rd_data_r,
	input wire logic rd_ack_r,
	// Data-ready pulse from the bank
	input wire logic fresh_sample_pin_r
);
	// Pulses seen, so the host can measure the real sample rate
	int unsigned ready_count;
	// Idle request lines from time zero
	initial begin
		rd_en = 1'b0;
		rd_addr = 7'h00;
		ready_count = 0;
	end
	// Rate correction needs the pulse frequency at zero decimation
	always @(posedge clk) begin
		if (fresh_sample_pin_r === 1'b1) begin
			ready_count <= ready_count + 1;
		end
	end
	// One read: single-cycle request, answer taken at the ack edge
	task automatic read(input logic [6:0] addr, output logic [15:0] data, output logic ack);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= addr;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		ack = rd_ack_r;
		data = rd_data_r;
		// A stale address must not look like the last request
		rd_addr <= ~addr;
	endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the output register bank
`timescale 1ns/1ps
module tb;
	// Clock, reset and stimulus
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reset_command = 1'b0;
	logic [15:0] miscellaneous_control = 16'h0000;
	logic [15:0] decimation_setting = 16'h0000;
	logic sample_valid = 1'b0;
	logic signed [23:0] gyro_x_rate = 24'h00_0000;
	logic [31:0] accel_z_sample = 32'h0000_0000;
	logic [15:0] temperature_sample = 16'h0000;
	logic sync_pin = 1'b0;
	// Read port and outputs
	logic rd_en;
	logic [6:0] rd_addr;
	logic [15:0] rd_data_r;
	logic rd_ack_r;
	logic fresh_sample_pin_r;
	// Bookkeeping
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] seen;
	logic [31:0] exp_angle;
	// Small stamp period keeps the run short
	iorb_top #(.RATE_W(24), .TS_TICK_CYCLES(8)) iorb_top_inst (.clk(clk), .sys_rst(sys_rst),
		.reset_command(reset_command), .miscellaneous_control(miscellaneous_control),
		.decimation_setting(decimation_setting), .sample_valid(sample_valid), .gyro_x_rate(gyro_x_rate),
		.accel_z_sample(accel_z_sample), .temperature_sample(temperature_sample), .sync_pin(sync_pin),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r),
		.fresh_sample_pin_r(fresh_sample_pin_r));
	iorb_host iorb_host_inst (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
		.rd_ack_r(rd_ack_r), .fresh_sample_pin_r(fresh_sample_pin_r));
	// 125 MHz clock
	always #4 clk = ~clk;
	// Hang guard, about the run length plus margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			err_count++;
			close_out();
		end
	end
	// Compare and report
	task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Read one register, ack must come back
	task automatic rd(input logic [6:0] addr, output logic [15:0] data);
		logic ack;
		iorb_host_inst.read(addr, data, ack);
		check("read ack", {15'h0000, ack}, 16'h0001);
	endtask
	// Read and compare
	task automatic rdc(input string name, input logic [6:0] addr, input logic [15:0] exp);
		logic [15:0] d;
		rd(addr, d);
		check(name, d, exp);
	endtask
	// One pre-decimation sample
	task automatic sample(input logic signed [23:0] r, input logic [31:0] a, input logic [15:0] t);
		@(posedge clk);
		sample_valid <= 1'b1;
		gyro_x_rate <= r;
		accel_z_sample <= a;
		temperature_sample <= t;
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask
	// Bounded wait for the data-ready pulse
	task automatic wait_fresh();
		int n;
		n = 0;
		while (fresh_sample_pin_r !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		check("fresh pulse", {15'h0000, fresh_sample_pin_r}, 16'h0001);
	endtask
	// Verdict, single exit
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		// Cleared bank before any update
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'h0000);
		rdc("angle high", iorb_pkg::ADDR_ANGLE_X_HIGH, 16'h0000);
		rdc("unmapped", 7'h20, 16'h0000);
		$display("test reset done");
		// Single-sample update, negative rate and accel
		sample(-24'sd5, 32'h8300_1234, 16'hfe70);
		wait_fresh();
		rdc("accel low", iorb_pkg::ADDR_ACCEL_Z_FRACTION, 16'h1234);
		rdc("accel high", iorb_pkg::ADDR_ACCEL_Z_WORD, 16'h8300);
		rdc("temperature", iorb_pkg::ADDR_DIE_TEMPERATURE, 16'hfe70);
		rdc("angle low", iorb_pkg::ADDR_ANGLE_X_LOW, 16'hfffb);
		rdc("angle high", iorb_pkg::ADDR_ANGLE_X_HIGH, 16'hffff);
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'h0001);
		$display("test single update done");
		// Three samples per result, previous sample carried in
		decimation_setting <= 16'h0002;
		sample(24'sd100, 32'h0000_0000, 16'h00fa);
		sample(-24'sd300, 32'h0000_0000, 16'h00fa);
		sample(24'sd7000, 32'h7d00_0001, 16'h041a);
		wait_fresh();
		exp_angle = 32'(-5 + 100) + 32'(100 - 300) + 32'(-300 + 7000);
		rdc("angle low", iorb_pkg::ADDR_ANGLE_X_LOW, exp_angle[15:0]);
		rdc("angle high", iorb_pkg::ADDR_ANGLE_X_HIGH, exp_angle[31:16]);
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'h0002);
		rdc("accel high", iorb_pkg::ADDR_ACCEL_Z_WORD, 16'h7d00);
		rdc("temperature", iorb_pkg::ADDR_DIE_TEMPERATURE, 16'h041a);
		$display("test decimation done");
		// Stamp stays idle outside scaled sync
		decimation_setting <= 16'h0000;
		sync_pin <= 1'b1;
		repeat (100) @(posedge clk);
		sample(24'sd0, 32'h0000_0000, 16'h0000);
		wait_fresh();
		rdc("stamp idle", iorb_pkg::ADDR_EDGE_ELAPSED_TIME, 16'h0000);
		// Scaled sync: about 12 counts after 100 cycles at 8 cycles a count
		miscellaneous_control <= 16'h0008;
		sync_pin <= 1'b0;
		repeat (10) @(posedge clk);
		sync_pin <= 1'b1;
		repeat (100) @(posedge clk);
		sample(24'sd0, 32'h0000_0000, 16'h0000);
		wait_fresh();
		rd(iorb_pkg::ADDR_EDGE_ELAPSED_TIME, seen);
		check("stamp range", {15'h0000, seen >= 16'h000a && seen <= 16'h000e}, 16'h0001);
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'h0004);
		check("ready pulses", 16'(iorb_host_inst.ready_count), 16'h0004);
		$display("test time stamp done");
		// Reset command, then count to the wrap
		@(posedge clk);
		reset_command <= 1'b1;
		@(posedge clk);
		reset_command <= 1'b0;
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'h0000);
		@(posedge clk);
		sample_valid <= 1'b1;
		repeat (65535) @(posedge clk);
		sample_valid <= 1'b0;
		repeat (4) @(posedge clk);
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'hffff);
		sample(24'sd0, 32'h0000_0000, 16'h0000);
		wait_fresh();
		rdc("counter", iorb_pkg::ADDR_UPDATE_COUNTER, 16'h0000);
		$display("test wrap done");
		close_out();
	end
endmodule
